// [src/dtp_consts.svh]
// register addresses, field positions, reset values and widths
`ifndef DTP_CONSTS_SVH
`define DTP_CONSTS_SVH

// ***************************************************
// widths
// ***************************************************
`define DTP_ADDR_W         9
`define DTP_DATA_W         16
`define DTP_LANES          4
`define DTP_WORD_W         10
`define DTP_CHANNELS       8

// ***************************************************
// register addresses
// ***************************************************
`define DTP_ADDR_BLACK_FAULT   9'h088
`define DTP_ADDR_RSVD_STAT_A   9'h089
`define DTP_ADDR_RSVD_STAT_B   9'h08a
`define DTP_ADDR_RSVD_STAT_C   9'h08b
`define DTP_ADDR_RSVD_CFG_A    9'h08c
`define DTP_ADDR_RSVD_CFG_B    9'h08d
`define DTP_ADDR_PAT_CTRL      9'h090
`define DTP_ADDR_RSVD_CFG_C    9'h091
`define DTP_ADDR_LANE01_LOW    9'h092
`define DTP_ADDR_LANE23_LOW    9'h093
`define DTP_ADDR_RSVD_CFG_D    9'h094
`define DTP_ADDR_LANE_HIGH     9'h096

// ***************************************************
// reset values
// ***************************************************
`define DTP_RST_PAT_CTRL       4'h0
`define DTP_RST_LANE01_LOW     16'h0100
`define DTP_RST_LANE23_LOW     16'h0302
`define DTP_RST_LANE_HIGH      8'h00
`define DTP_RST_BLACK_FAULT    8'h00
`define DTP_RST_RSVD_CFG_B     16'hffff
`define DTP_RST_RSVD_CFG_D     16'h0504

// ***************************************************
// pattern_control fields
// ***************************************************
`define DTP_CTRL_INSERT        0
`define DTP_CTRL_RAMP          1
`define DTP_CTRL_PRBS          2
`define DTP_CTRL_FRAMED        3
`define DTP_CTRL_W             4

// ***************************************************
// prbs generator
// ***************************************************
`define DTP_PRBS_LEN           9
`define DTP_PRBS_TAP           5
`define DTP_PRBS_SEED          9'h1ff

`endif

// [src/dtp_pkg.sv]
// types shared by the datapath test pattern generator
`include "dtp_consts.svh"
package dtp_pkg;

  typedef logic [`DTP_WORD_W-1:0] dtp_word_type;

  typedef enum logic [1:0] {
    DTP_SRC_PIXEL,
    DTP_SRC_CONST,
    DTP_SRC_RAMP,
    DTP_SRC_PRBS
  } dtp_src_type;

  typedef struct packed {
    logic [`DTP_CTRL_W-1:0]                  ctrl;
    logic [`DTP_DATA_W-1:0]                  low01;
    logic [`DTP_DATA_W-1:0]                  low23;
    logic [7:0]                              high;
    logic [`DTP_CHANNELS-1:0]                flags;
    logic [`DTP_DATA_W-1:0]                  rdata;
    logic                                    rvalid;
    logic [`DTP_LANES*`DTP_WORD_W-1:0]       odata;
    logic                                    ovalid;
    logic                                    oframe;
    dtp_src_type                             src;
  } dtp_top_state_type;

  typedef struct packed {
    logic [`DTP_LANES-1:0][`DTP_WORD_W-1:0]  val;
  } dtp_pat_state_type;

  typedef struct packed {
    logic [`DTP_PRBS_LEN-1:0]                lfsr;
    dtp_word_type                            word;
  } dtp_prbs_state_type;

endpackage : dtp_pkg

// [src/dtp_link_if.sv]
// carrier between the top and its pattern and prbs generators
`include "dtp_consts.svh"
interface dtp_link_if;
  import dtp_pkg::*;

  logic                                    pat_load;
  logic                                    pat_adv;
  logic [`DTP_LANES-1:0][`DTP_WORD_W-1:0]  pat_seed;
  logic [`DTP_LANES-1:0][`DTP_WORD_W-1:0]  pat_val;
  logic                                    prbs_restart;
  logic                                    prbs_adv;
  dtp_word_type                            prbs_word;

  modport ctl (
    output pat_load,
    output pat_adv,
    output pat_seed,
    input  pat_val,
    output prbs_restart,
    output prbs_adv,
    input  prbs_word
  );

  modport pat (
    input  pat_load,
    input  pat_adv,
    input  pat_seed,
    output pat_val
  );

  modport prbs (
    input  prbs_restart,
    input  prbs_adv,
    output prbs_word
  );
endinterface : dtp_link_if

// [src/dtp_pat.sv]
// per-lane constant / incrementing test value holders
`include "dtp_consts.svh"
module dtp_pat
  import dtp_pkg::*;
(
  input wire logic   clk_sys,
  input wire logic   rst_sync_b,
  dtp_link_if.pat    lnk
);

  dtp_pat_state_type st_r;
  dtp_pat_state_type st_nxt;

  function automatic dtp_word_type inc_word(input dtp_word_type w);
    inc_word = w + 10'h001;
  endfunction : inc_word

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < `DTP_LANES; i++) begin
      if (lnk.pat_load && lnk.pat_adv) begin
        // the seed goes out on this slot, so the next word is one above it
        st_nxt.val[i] = inc_word(lnk.pat_seed[i]);
      end else if (lnk.pat_load) begin
        st_nxt.val[i] = lnk.pat_seed[i];
      end else if (lnk.pat_adv) begin
        // wraps 0x3ff -> 0x000 by width
        st_nxt.val[i] = inc_word(st_r.val[i]);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.pat_val = st_r.val;
endmodule : dtp_pat

// [src/dtp_prbs.sv]
// prbs9 word generator, ten bits per advance
`include "dtp_consts.svh"
module dtp_prbs
  import dtp_pkg::*;
(
  input wire logic   clk_sys,
  input wire logic   rst_sync_b,
  dtp_link_if.prbs   lnk
);

  dtp_prbs_state_type st_r;
  dtp_prbs_state_type st_nxt;

  function automatic logic [`DTP_PRBS_LEN+`DTP_WORD_W-1:0] step_word(
    input logic [`DTP_PRBS_LEN-1:0] s);
    logic [`DTP_PRBS_LEN-1:0] l;
    dtp_word_type             w;
    logic                     b;
    l = s;
    w = '0;
    for (int k = 0; k < `DTP_WORD_W; k++) begin
      b = l[`DTP_PRBS_LEN-1] ^ l[`DTP_PRBS_TAP-1];
      l = {l[`DTP_PRBS_LEN-2:0], b};
      w = {w[`DTP_WORD_W-2:0], b};
    end
    step_word = {l, w};
  endfunction : step_word

  always_comb begin
    st_nxt = st_r;
    if (lnk.prbs_restart) begin
      st_nxt.lfsr = `DTP_PRBS_SEED;
      st_nxt.word = '0;
    end else if (lnk.prbs_adv) begin
      {st_nxt.lfsr, st_nxt.word} = step_word(st_r.lfsr);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= {`DTP_PRBS_SEED, 10'h000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.prbs_word = st_r.word;
endmodule : dtp_prbs

// [src/dtp_top.sv]
// output datapath test pattern generator and black fault flags
`include "dtp_consts.svh"
module dtp_top
  import dtp_pkg::*;
(
  input  wire logic                                clk_sys,
  input  wire logic                                rst_b,
  input  wire logic [`DTP_ADDR_W-1:0]              reg_addr,
  input  wire logic [`DTP_DATA_W-1:0]              reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [`DTP_DATA_W-1:0]              reg_rdata,
  output logic                                     reg_rvalid,
  input  wire logic [`DTP_LANES*`DTP_WORD_W-1:0]   pix_data,
  input  wire logic                                pix_valid,
  input  wire logic                                frame_valid,
  input  wire logic                                frame_start,
  input  wire logic                                cal_start,
  input  wire logic                                cal_done,
  input  wire logic [`DTP_CHANNELS-1:0]            cal_short,
  output logic      [`DTP_LANES*`DTP_WORD_W-1:0]   out_data,
  output logic                                     out_valid,
  output logic                                     out_frame,
  output dtp_src_type                              out_source,
  output logic      [`DTP_CHANNELS-1:0]            black_cal_invalid
);

  // ***************************************************
  // reset release
  // ***************************************************
  logic [1:0] rst_pipe_r;
  logic       rst_sync_b;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_r <= 2'b00;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end

  assign rst_sync_b = rst_pipe_r[1];

  // ***************************************************
  // generators
  // ***************************************************
  dtp_link_if lnk ();

  dtp_pat u_pat (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .lnk        (lnk.pat)
  );

  dtp_prbs u_prbs (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .lnk        (lnk.prbs)
  );

  // ***************************************************
  // helpers
  // ***************************************************
  dtp_top_state_type st_r;
  dtp_top_state_type st_nxt;

  // builds the 10-bit programmed value of one lane from the low and high
  // registers
  function automatic dtp_word_type lane_seed(
    input logic [1:0] lane,
    input logic [`DTP_DATA_W-1:0] low01,
    input logic [`DTP_DATA_W-1:0] low23,
    input logic [7:0] high);
    logic [7:0] lo;
    logic [1:0] hi;
    case (lane)
      2'h0: begin
        lo = low01[7:0];
        hi = high[1:0];
      end
      2'h1: begin
        lo = low01[15:8];
        hi = high[3:2];
      end
      2'h2: begin
        lo = low23[7:0];
        hi = high[5:4];
      end
      default: begin
        lo = low23[15:8];
        hi = high[7:6];
      end
    endcase
    lane_seed = {hi, lo};
  endfunction : lane_seed

  // read answer; reserved words show their fixed values and unmapped
  // addresses read zero
  function automatic logic [`DTP_DATA_W-1:0] reg_read(
    input logic [`DTP_ADDR_W-1:0] a,
    input dtp_top_state_type s);
    case (a)
      `DTP_ADDR_BLACK_FAULT: reg_read = {8'h00, s.flags};
      `DTP_ADDR_PAT_CTRL:    reg_read = {12'h000, s.ctrl};
      `DTP_ADDR_LANE01_LOW:  reg_read = s.low01;
      `DTP_ADDR_LANE23_LOW:  reg_read = s.low23;
      `DTP_ADDR_LANE_HIGH:   reg_read = {8'h00, s.high};
      `DTP_ADDR_RSVD_CFG_B:  reg_read = `DTP_RST_RSVD_CFG_B;
      `DTP_ADDR_RSVD_CFG_D:  reg_read = `DTP_RST_RSVD_CFG_D;
      default:               reg_read = 16'h0000;
    endcase
  endfunction : reg_read

  function automatic logic is_value_reg(input logic [`DTP_ADDR_W-1:0] a);
    is_value_reg = (a == `DTP_ADDR_LANE01_LOW) ||
                   (a == `DTP_ADDR_LANE23_LOW) ||
                   (a == `DTP_ADDR_LANE_HIGH);
  endfunction : is_value_reg

  // ***************************************************
  // datapath decisions
  // ***************************************************
  logic insert_on;
  logic prbs_on;
  logic ramp_on;
  logic framed_on;
  logic word_slot;
  logic value_wr;
  logic [`DTP_DATA_W-1:0] seed_low01;
  logic [`DTP_DATA_W-1:0] seed_low23;
  logic [7:0]             seed_high;

  always_comb begin
    insert_on = st_r.ctrl[`DTP_CTRL_INSERT];
    prbs_on   = st_r.ctrl[`DTP_CTRL_PRBS];
    ramp_on   = st_r.ctrl[`DTP_CTRL_RAMP];
    framed_on = st_r.ctrl[`DTP_CTRL_FRAMED];
    value_wr  = reg_wr && is_value_reg(reg_addr);
    // unframed patterns run every cycle, framed ones only on pixel slots
    if ((insert_on || prbs_on) && !framed_on) begin
      word_slot = 1'b1;
    end else if (insert_on || prbs_on) begin
      word_slot = pix_valid && frame_valid;
    end else begin
      word_slot = pix_valid;
    end
  end

  always_comb begin
    // a value write reloads the ramp in its own cycle, so the seed must
    // already carry the written word, not the one it replaces
    seed_low01 = (reg_wr && reg_addr == `DTP_ADDR_LANE01_LOW) ?
                 reg_wdata : st_r.low01;
    seed_low23 = (reg_wr && reg_addr == `DTP_ADDR_LANE23_LOW) ?
                 reg_wdata : st_r.low23;
    seed_high  = (reg_wr && reg_addr == `DTP_ADDR_LANE_HIGH) ?
                 reg_wdata[7:0] : st_r.high;
    for (int i = 0; i < `DTP_LANES; i++) begin
      lnk.pat_seed[i] = lane_seed(i[1:0], seed_low01, seed_low23,
                                  seed_high);
    end
    // the ramp restarts from the programmed value whenever insertion is off,
    // a value register is rewritten, or a new frame starts in framed mode
    lnk.pat_load     = !insert_on || value_wr ||
                       (framed_on && frame_start);
    lnk.pat_adv      = word_slot && insert_on && ramp_on;
    lnk.prbs_restart = !prbs_on || (framed_on && frame_start);
    lnk.prbs_adv     = word_slot && prbs_on;
  end

  // ***************************************************
  // state update
  // ***************************************************
  always_comb begin
    st_nxt = st_r;

    // register writes; read-only and reserved words ignore them
    if (reg_wr) begin
      case (reg_addr)
        `DTP_ADDR_PAT_CTRL:   st_nxt.ctrl  = reg_wdata[`DTP_CTRL_W-1:0];
        `DTP_ADDR_LANE01_LOW: st_nxt.low01 = reg_wdata;
        `DTP_ADDR_LANE23_LOW: st_nxt.low23 = reg_wdata;
        `DTP_ADDR_LANE_HIGH:  st_nxt.high  = reg_wdata[7:0];
        default: begin
        end
      endcase
    end

    // read answer one cycle after the strobe
    st_nxt.rvalid = reg_rd;
    if (reg_rd) begin
      st_nxt.rdata = reg_read(reg_addr, st_r);
    end

    // a new calibration clears the flags; a fault reported in the same
    // cycle still sets its flag
    if (cal_start) begin
      st_nxt.flags = '0;
    end
    if (cal_done) begin
      st_nxt.flags = st_nxt.flags | cal_short;
    end

    // output datapath
    st_nxt.ovalid = word_slot;
    st_nxt.oframe = (insert_on || prbs_on) && !framed_on ?
                    1'b0 : frame_valid;
    if (prbs_on) begin
      st_nxt.src = DTP_SRC_PRBS;
      st_nxt.odata = {`DTP_LANES{lnk.prbs_word}};
    end else if (insert_on && ramp_on) begin
      st_nxt.src = DTP_SRC_RAMP;
      // a reload on a slot shows the seed itself; the ramp steps from it
      st_nxt.odata = lnk.pat_load ? lnk.pat_seed : lnk.pat_val;
    end else if (insert_on) begin
      st_nxt.src = DTP_SRC_CONST;
      st_nxt.odata = lnk.pat_seed;
    end else begin
      st_nxt.src = DTP_SRC_PIXEL;
      st_nxt.odata = pix_data;
    end
    if (!word_slot) begin
      st_nxt.odata = st_r.odata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r.ctrl   <= `DTP_RST_PAT_CTRL;
      st_r.low01  <= `DTP_RST_LANE01_LOW;
      st_r.low23  <= `DTP_RST_LANE23_LOW;
      st_r.high   <= `DTP_RST_LANE_HIGH;
      st_r.flags  <= `DTP_RST_BLACK_FAULT;
      st_r.rdata  <= '0;
      st_r.rvalid <= 1'b0;
      st_r.odata  <= '0;
      st_r.ovalid <= 1'b0;
      st_r.oframe <= 1'b0;
      st_r.src    <= DTP_SRC_PIXEL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign reg_rdata         = st_r.rdata;
  assign reg_rvalid        = st_r.rvalid;
  assign out_data          = st_r.odata;
  assign out_valid         = st_r.ovalid;
  assign out_frame         = st_r.oframe;
  assign out_source        = st_r.src;
  assign black_cal_invalid = st_r.flags;

endmodule : dtp_top

// [bench/dtp_top_checker.sv]
// concurrent checks on the test pattern generator ports
`include "dtp_consts.svh"
module dtp_top_checker
  import dtp_pkg::*;
(
  input wire logic                              clk_sys,
  input wire logic                              rst_b,
  input wire logic                              reg_wr,
  input wire logic                              reg_rd,
  input wire logic                              reg_rvalid,
  input wire logic [`DTP_LANES*`DTP_WORD_W-1:0] pix_data,
  input wire logic                              pix_valid,
  input wire logic                              frame_valid,
  input wire logic                              frame_start,
  input wire logic                              cal_start,
  input wire logic                              cal_done,
  input wire logic [`DTP_CHANNELS-1:0]          cal_short,
  input wire logic [`DTP_LANES*`DTP_WORD_W-1:0] out_data,
  input wire logic                              out_valid,
  input wire logic                              out_frame,
  input wire dtp_src_type                       out_source,
  input wire logic [`DTP_CHANNELS-1:0]          black_cal_invalid
);
  // ***************************************************
  // properties
  // ***************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_flag_set;
    cal_done |=> (black_cal_invalid & $past(cal_short)) == $past(cal_short);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("fault flag not set by calibration result");

  property p_flag_clr;
    cal_start && !cal_done |=> black_cal_invalid == 8'h00;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("fault flags not cleared");

  // software writes must never disturb the flags
  property p_flag_hold;
    !cal_start && !cal_done |=> $stable(black_cal_invalid);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("fault flags changed without calibration event");

  property p_rd_ans;
    reg_rvalid == $past(reg_rd);
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer not one cycle after request");

  property p_pix;
    out_valid && out_source == DTP_SRC_PIXEL
      |-> $past(pix_valid) && out_data == $past(pix_data);
  endproperty
  a_pix: assert property (p_pix)
    else $error("pixel word not passed through");

  property p_ramp;
    out_valid && out_source == DTP_SRC_RAMP
    ##1 out_valid && out_source == DTP_SRC_RAMP && !$past(frame_start)
        && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> out_data[9:0] == 10'($past(out_data[9:0]) + 10'h001)
        && out_data[39:30] == 10'($past(out_data[39:30]) + 10'h001);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp word did not advance by one");

  property p_const;
    out_valid && out_source == DTP_SRC_CONST
    ##1 out_valid && out_source == DTP_SRC_CONST && !$past(reg_wr)
        && !$past(reg_wr, 2)
    |-> $stable(out_data);
  endproperty
  a_const: assert property (p_const)
    else $error("constant pattern moved");

  property p_prbs;
    out_valid && out_source == DTP_SRC_PRBS |-> out_data == {4{out_data[9:0]}};
  endproperty
  a_prbs: assert property (p_prbs)
    else $error("prbs word differs between lanes");

  property p_frame;
    out_frame |-> $past(frame_valid);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame flag outside frame window");
endmodule : dtp_top_checker

bind dtp_top dtp_top_checker u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .pix_data(pix_data), .pix_valid(pix_valid),
  .frame_valid(frame_valid), .frame_start(frame_start),
  .cal_start(cal_start), .cal_done(cal_done), .cal_short(cal_short),
  .out_data(out_data), .out_valid(out_valid), .out_frame(out_frame),
  .out_source(out_source), .black_cal_invalid(black_cal_invalid)
);

// [bench/dtp_rx_model.sv]
// downstream receiver model capturing each output word
`include "dtp_consts.svh"
module dtp_rx_model
(
  input  wire logic                              clk_sys,
  input  wire logic [`DTP_LANES*`DTP_WORD_W-1:0] rx_data,
  input  wire logic                              rx_valid,
  output logic      [`DTP_LANES*`DTP_WORD_W-1:0] last_word,
  output int                                     word_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // no back-pressure exists, so every valid word is taken at once
  initial begin
    last_word = '0;
    word_cnt = 0;
    forever begin
      @(posedge clk_sys);
      if (rx_valid === 1'b1) begin
        last_word <= rx_data;
        word_cnt <= word_cnt + 1;
      end
    end
  end
endmodule : dtp_rx_model

// [bench/dtp_top_tb.sv]
// self-checking bench for the datapath test pattern generator
`include "dtp_consts.svh"
module dtp_top_tb
  import dtp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ***************************************************
  // signals
  // ***************************************************
  logic              clk_sys, rst_b, reg_wr, reg_rd, reg_rvalid;
  logic [8:0]        reg_addr;
  logic [15:0]       reg_wdata, reg_rdata;
  logic [39:0]       pix_data, out_data, rx_word, w;
  logic              pix_valid, frame_valid, frame_start, out_valid;
  logic              cal_start, cal_done, out_frame;
  logic [7:0]        cal_short, black_cal_invalid;
  dtp_src_type       out_source;
  int                rx_cnt, k;
  int                n_errors = 0;
  int                checks_done = 0;
  int                cycles = 0;
  logic [8:0]        ra [9] = '{9'h090, 9'h092, 9'h093, 9'h096, 9'h088,
                                9'h08d, 9'h094, 9'h089, 9'h0a0};
  logic [15:0]       re [9] = '{16'h0000, 16'h0100, 16'h0302, 16'h0000,
                                16'h0000, 16'hffff, 16'h0504, 16'h0000,
                                16'h0000};

  dtp_top uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pix_data(pix_data),
    .pix_valid(pix_valid), .frame_valid(frame_valid),
    .frame_start(frame_start), .cal_start(cal_start), .cal_done(cal_done),
    .cal_short(cal_short), .out_data(out_data), .out_valid(out_valid),
    .out_frame(out_frame), .out_source(out_source),
    .black_cal_invalid(black_cal_invalid)
  );
  dtp_rx_model rx (
    .clk_sys(clk_sys), .rx_data(out_data), .rx_valid(out_valid),
    .last_word(rx_word), .word_cnt(rx_cnt)
  );

  // ***************************************************
  // tasks
  // ***************************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic reg_write(input logic [8:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : reg_write

  task automatic reg_chk(input logic [8:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check(40'(reg_rvalid), 40'h1);
    check(40'(reg_rdata), 40'(exp));
  endtask : reg_chk

  function automatic logic [39:0] inc4(input logic [39:0] v);
    for (int i = 0; i < 4; i++) begin
      inc4[10*i+:10] = v[10*i+:10] + 10'h001;
    end
  endfunction : inc4

  task automatic pulse_cal(input logic st, input logic dn, logic [7:0] s);
    @(negedge clk_sys);
    cal_start = st;
    cal_done = dn;
    cal_short = s;
    @(negedge clk_sys);
    {cal_start, cal_done} = 2'b00;
  endtask : pulse_cal

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // a hang is cut short well beyond the hundred or so cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    {reg_wr, reg_rd, pix_valid, frame_valid, frame_start} = '0;
    {cal_start, cal_done, cal_short, reg_addr, reg_wdata, pix_data} = '0;
    rst_b = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (k = 0; k < 9; k++) begin
      reg_chk(ra[k], re[k]);
    end
    reg_write(9'h090, 16'hfff0);
    reg_chk(9'h090, 16'h0000);
    reg_write(9'h088, 16'h00ff);
    reg_chk(9'h088, 16'h0000);
    @(negedge clk_sys);
    pix_data = 40'h5a3c96e1f0;
    pix_valid = 1'b1;
    @(negedge clk_sys);
    pix_valid = 1'b0;
    check(40'(out_valid), 40'h1);
    check(out_data, 40'h5a3c96e1f0);
    @(negedge clk_sys);
    check(rx_word, 40'h5a3c96e1f0);
    reg_write(9'h092, 16'ha5b4);
    reg_write(9'h093, 16'h1e2f);
    reg_write(9'h096, 16'hffe4);
    reg_chk(9'h096, 16'h00e4);
    reg_write(9'h090, 16'h0001);
    repeat (4) @(negedge clk_sys);
    check(out_data, {10'h31e, 10'h22f, 10'h1a5, 10'h0b4});
    check(40'(out_source), 40'(DTP_SRC_CONST));
    check(40'(out_frame), 40'h0);
    check(rx_word, {10'h31e, 10'h22f, 10'h1a5, 10'h0b4});
    reg_write(9'h092, 16'ha5fe);
    reg_write(9'h096, 16'h00e7);
    reg_write(9'h090, 16'h0003);
    @(negedge clk_sys);
    w = out_data;
    check(w, {10'h31e, 10'h22f, 10'h1a5, 10'h3fe});
    for (k = 0; k < 4; k++) begin
      @(negedge clk_sys);
      check(out_data, inc4(w));
      w = inc4(w);
    end
    reg_write(9'h090, 16'h000b);
    repeat (2) @(negedge clk_sys);
    k = rx_cnt;
    repeat (4) @(negedge clk_sys);
    check(40'(out_valid), 40'h0);
    check(40'(rx_cnt), 40'(k));
    frame_start = 1'b1;
    frame_valid = 1'b1;
    pix_valid = 1'b1;
    @(negedge clk_sys);
    frame_start = 1'b0;
    check(out_data, {10'h31e, 10'h22f, 10'h1a5, 10'h3fe});
    check(40'(out_frame), 40'h1);
    @(negedge clk_sys);
    check(out_data, {10'h31f, 10'h230, 10'h1a6, 10'h3ff});
    {frame_valid, pix_valid} = 2'b00;
    repeat (2) @(negedge clk_sys);
    check(40'(out_frame), 40'h0);
    reg_write(9'h090, 16'h0004);
    @(negedge clk_sys);
    check(out_data, 40'h0);
    @(negedge clk_sys);
    check(out_data, {4{10'h01e}});
    @(negedge clk_sys);
    check(40'(out_source), 40'(DTP_SRC_PRBS));
    reg_write(9'h090, 16'h0007);
    repeat (3) @(negedge clk_sys);
    check(40'(out_source), 40'(DTP_SRC_PRBS));
    check(out_data, {4{out_data[9:0]}});
    pulse_cal(1'b0, 1'b1, 8'h05);
    check(40'(black_cal_invalid), 40'h05);
    reg_chk(9'h088, 16'h0005);
    pulse_cal(1'b0, 1'b1, 8'h80);
    check(40'(black_cal_invalid), 40'h85);
    pulse_cal(1'b1, 1'b1, 8'h02);
    check(40'(black_cal_invalid), 40'h02);
    pulse_cal(1'b1, 1'b0, 8'h00);
    check(40'(black_cal_invalid), 40'h00);
    summarize();
  end
endmodule : dtp_top_tb
